//--- design/ivp_pkg.sv
// package for the interrupt vector and priority map
// assumes a 32-bit apb slave on pclk; one word per register
package ivp_pkg;

   localparam int NUM_LINES = 24;
   localparam int LVL_W = 2;
   localparam int LINE_W = 5;
   localparam int NUM_LVL_REGS = 6;
   localparam int FIELDS_PER_REG = 4;
   localparam int ADDR_W = 12;
   localparam int EXT_W = 8;

   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_LVL0 = 8'h79;
   localparam logic [7:0] IDX_LVL5 = 8'h7e;
   localparam logic [7:0] IDX_STATUS = 8'h80;
   localparam logic [7:0] IDX_MASK = 8'h81;
   localparam logic [7:0] IDX_STATE = 8'h82;

   // reset values
   localparam logic [7:0] LVL_RST = 8'hff;
   localparam logic [23:0] STATUS_RST = 24'h000000;
   localparam logic [23:0] MASK_RST = 24'h000000;

   // request line assignments
   localparam int LINE_EXT4 = 0;
   localparam int LINE_EXT5 = 1;
   localparam int LINE_EXT26 = 2;
   localparam int LINE_EXT37 = 3;
   localparam int LINE_CT0_LO = 5;
   localparam int LINE_CT0_HI = 6;
   localparam int LINE_CT1_HI = 14;
   localparam int LINE_CT1_LO = 22;

   // vector of line 0; each later line sits two bytes lower
   localparam logic [15:0] VEC_TOP_HI = 16'hfffa;
   localparam logic [15:0] VEC_TOP_LO = 16'hfffb;

   // current-request register layout
   localparam int STATE_LINE_POS = 0;
   localparam int STATE_LEVEL_POS = 8;
   localparam int STATE_VALID_POS = 16;

   typedef struct packed {
      logic [NUM_LVL_REGS-1:0][7:0] lvl;
      logic [NUM_LINES-1:0] status;
      logic [NUM_LINES-1:0] mask;
      logic req;
      logic [LINE_W-1:0] line;
      logic [LVL_W-1:0] level;
      logic [15:0] vec_hi;
      logic [15:0] vec_lo;
      logic [31:0] rdata;
   } ivp_state_s;

endpackage

//--- design/ivp_arbiter.sv
// level and fixed-order arbiter over the request lines
// assumes requests and levels are on the same clock as the caller
`timescale 1ns/100ps
module ivp_arbiter
   import ivp_pkg::*;
#(
   parameter int N = NUM_LINES,
   parameter int W = LVL_W,
   parameter int LW = LINE_W
) (
   input wire logic [N-1:0] req,
   input wire logic [N*W-1:0] levels,
   input wire logic [W-1:0] cur_level,
   output logic valid,
   output logic [LW-1:0] line,
   output logic [W-1:0] level
);

   logic found;
   logic [W-1:0] best;
   logic [LW-1:0] best_line;

   always_comb begin
      found = 1'b0;
      best = '1;
      best_line = '0;
      // walk from the last line down; ties go to the lower number
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && (!found || levels[i*W +: W] <= best)) begin
            found = 1'b1;
            best = levels[i*W +: W];
            best_line = LW'(i);
         end
      end
      // lower value is more urgent than the cpu level
      valid = found && (best < cur_level);
      line = best_line;
      level = best;
   end

endmodule

//--- design/ivp_map.sv
// interrupt vector and priority map with apb level registers
// assumes sources and cpu on pclk; apb master on the same clock
//
// Summary of operation
// - 24 lines, vectors from fffa downward.
// - two-bit level field per line.
// - equal levels: lowest line number wins.
// - external ch 4 and 5 on lines 0, 1.
// - external ch 2 and 6 share line 2.
// - external ch 3 and 7 share line 3.
// - timer 0 low line 5, high line 6.
// - timer 1 high line 14, low 22.
// - level registers read/write, reset all ones.
`timescale 1ns/100ps
module ivp_map
   import ivp_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [EXT_W-1:0] ext_int,
   input wire logic ct0_lo_req,
   input wire logic ct0_hi_req,
   input wire logic ct1_lo_req,
   input wire logic ct1_hi_req,
   input wire logic [NUM_LINES-1:0] other_req,
   input wire logic [LVL_W-1:0] cpu_level,
   output logic cpu_irq_req,
   output logic [LINE_W-1:0] cpu_irq_line,
   output logic [LVL_W-1:0] cpu_irq_level,
   output logic [15:0] cpu_vec_upper,
   output logic [15:0] cpu_vec_lower,
   output logic int_o
);

   ivp_state_s st_r;
   ivp_state_s st_nxt;
   logic [NUM_LINES-1:0] line_req;
   logic [NUM_LINES-1:0] eff_req;
   logic arb_valid;
   logic [LINE_W-1:0] arb_line;
   logic [LVL_W-1:0] arb_level;
   logic [7:0] idx;
   logic hit;
   logic [31:0] rd_word;
   logic acc;
   logic wr;

   // source routing per line
   for (genvar i = 0; i < NUM_LINES; i++) begin : g_line
      if (i == LINE_EXT4) begin : g_e4
         assign line_req[i] = ext_int[4];
      end else if (i == LINE_EXT5) begin : g_e5
         assign line_req[i] = ext_int[5];
      end else if (i == LINE_EXT26) begin : g_e26
         assign line_req[i] = ext_int[2] | ext_int[6];
      end else if (i == LINE_EXT37) begin : g_e37
         assign line_req[i] = ext_int[3] | ext_int[7];
      end else if (i == LINE_CT0_LO) begin : g_t0l
         assign line_req[i] = ct0_lo_req;
      end else if (i == LINE_CT0_HI) begin : g_t0h
         assign line_req[i] = ct0_hi_req;
      end else if (i == LINE_CT1_HI) begin : g_t1h
         assign line_req[i] = ct1_hi_req;
      end else if (i == LINE_CT1_LO) begin : g_t1l
         assign line_req[i] = ct1_lo_req;
      end else begin : g_oth
         assign line_req[i] = other_req[i];
      end
   end

   assign eff_req = line_req & st_r.mask;

   ivp_arbiter #(
      .N(NUM_LINES),
      .W(LVL_W),
      .LW(LINE_W)
   ) u_arb (
      .req(eff_req),
      .levels(st_r.lvl),
      .cur_level(cpu_level),
      .valid(arb_valid),
      .line(arb_line),
      .level(arb_level)
   );

   // address decode and read mux
   assign idx = paddr[9:2];
   assign acc = psel & penable & ce;
   assign wr = acc & pwrite;

   always_comb begin
      hit = 1'b0;
      rd_word = 32'h00000000;
      if (paddr[ADDR_W-1:10] == '0 && paddr[1:0] == 2'b00) begin
         if (idx >= IDX_LVL0 && idx <= IDX_LVL5) begin
            hit = 1'b1;
            rd_word = {24'h000000, st_r.lvl[3'(idx - IDX_LVL0)]};
         end else if (idx == IDX_STATUS) begin
            hit = 1'b1;
            rd_word = {8'h00, st_r.status};
         end else if (idx == IDX_MASK) begin
            hit = 1'b1;
            rd_word = {8'h00, st_r.mask};
         end else if (idx == IDX_STATE) begin
            hit = 1'b1;
            rd_word[STATE_LINE_POS +: LINE_W] = st_r.line;
            rd_word[STATE_LEVEL_POS +: LVL_W] = st_r.level;
            rd_word[STATE_VALID_POS] = st_r.req;
         end
      end
   end

   always_comb begin
      st_nxt = st_r;
      if (ce) begin
         // set wins over a write-one clear in the same cycle
         if (wr && hit && idx == IDX_STATUS) begin
            st_nxt.status = (st_r.status & ~pwdata[NUM_LINES-1:0]) | line_req;
         end else begin
            st_nxt.status = st_r.status | line_req;
         end
         if (wr && hit && idx >= IDX_LVL0 && idx <= IDX_LVL5) begin
            st_nxt.lvl[3'(idx - IDX_LVL0)] = pwdata[7:0];
         end
         if (wr && hit && idx == IDX_MASK) begin
            st_nxt.mask = pwdata[NUM_LINES-1:0];
         end
         // presented request with its vector pair
         st_nxt.req = arb_valid;
         st_nxt.line = arb_line;
         st_nxt.level = arb_level;
         st_nxt.vec_hi = VEC_TOP_HI - {10'h000, arb_line, 1'b0};
         st_nxt.vec_lo = VEC_TOP_LO - {10'h000, arb_line, 1'b0};
         // read data captured in the setup phase
         if (psel && !penable) begin
            st_nxt.rdata = rd_word;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.lvl <= {NUM_LVL_REGS{LVL_RST}};
         st_r.status <= STATUS_RST;
         st_r.mask <= MASK_RST;
         st_r.req <= 1'b0;
         st_r.line <= '0;
         st_r.level <= '1;
         st_r.vec_hi <= VEC_TOP_HI;
         st_r.vec_lo <= VEC_TOP_LO;
         st_r.rdata <= 32'h00000000;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = ce;
   assign pslverr = psel & penable & ~hit;
   assign cpu_irq_req = st_r.req;
   assign cpu_irq_line = st_r.line;
   assign cpu_irq_level = st_r.level;
   assign cpu_vec_upper = st_r.vec_hi;
   assign cpu_vec_lower = st_r.vec_lo;
   assign int_o = |(st_r.status & st_r.mask);

   // checks
   vec_upper_calc_a: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_irq_req |-> cpu_vec_upper == VEC_TOP_HI - {10'h000, cpu_irq_line, 1'b0})
      else $error("upper vector does not match line");
   vec_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
      cpu_irq_req |-> cpu_vec_lower == cpu_vec_upper + 16'h0001)
      else $error("lower vector not one above upper");
   level_field_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ce) && cpu_irq_req |->
      cpu_irq_level == LVL_W'($past(st_r.lvl[cpu_irq_line / 4]) >> (2 * (cpu_irq_line % 4))))
      else $error("presented level is not the line field");
   line0_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && eff_req[0] && st_r.lvl[0][1:0] == 2'h0 && cpu_level != 2'h0 |=>
      cpu_irq_req && cpu_irq_line == '0)
      else $error("line 0 did not take precedence");
   ext4_route_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ext_int[4] ##1 ce && ext_int[5] |=> st_r.status[LINE_EXT4] && st_r.status[LINE_EXT5])
      else $error("external 4 or 5 not on lines 0 and 1");
   ext6_share_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ext_int[6] |=> st_r.status[LINE_EXT26])
      else $error("external 6 not on line 2");
   ext7_share_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ext_int[7] |=> st_r.status[LINE_EXT37])
      else $error("external 7 not on line 3");
   timer0_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ct0_hi_req && !ct0_lo_req |=> st_r.status[LINE_CT0_HI])
      else $error("timer 0 high not on line 6");
   timer1_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ct1_lo_req |=> st_r.status[LINE_CT1_LO])
      else $error("timer 1 low not on line 22");
   level_reset_a: assert property (@(posedge pclk)
      !presetn |-> st_r.lvl == {NUM_LVL_REGS{LVL_RST}})
      else $error("level registers not all ones in reset");
   cpu_urgent_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ce) && cpu_irq_req |-> cpu_irq_level < $past(cpu_level))
      else $error("request not more urgent than cpu level");
   ext4_alone_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !ext_int[4] && !st_r.status[LINE_EXT4] |=> !st_r.status[LINE_EXT4])
      else $error("line 0 set without external 4");
   ext5_alone_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !ext_int[5] && !st_r.status[LINE_EXT5] |=> !st_r.status[LINE_EXT5])
      else $error("line 1 set without external 5");
   ext2_share_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ext_int[2] |=> st_r.status[LINE_EXT26])
      else $error("external 2 not on line 2");
   ext3_share_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ext_int[3] |=> st_r.status[LINE_EXT37])
      else $error("external 3 not on line 3");
   timer0_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ct0_lo_req |=> st_r.status[LINE_CT0_LO])
      else $error("timer 0 low not on line 5");
   timer1_high_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && ct1_hi_req |=> st_r.status[LINE_CT1_HI])
      else $error("timer 1 high not on line 14");
   level_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && hit && idx == IDX_LVL0 |=> st_r.lvl[0] == $past(pwdata[7:0]))
      else $error("level register write lost");
   cpu_block_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cpu_level == 2'h0 |=> !cpu_irq_req)
      else $error("request presented over most urgent cpu level");
   mask_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
      $past(ce) && cpu_irq_req |-> (($past(st_r.mask) >> cpu_irq_line) & 24'h000001) != '0)
      else $error("masked line presented");
   status_sticky_a: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !wr |=> ($past(st_r.status) & ~st_r.status) == '0)
      else $error("status bit lost without clear");
   ce_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ce |=> st_r == $past(st_r))
      else $error("state moved while clock enable low");
   bad_write_a: assert property (@(posedge pclk) disable iff (!presetn)
      wr && !hit |=> st_r.mask == $past(st_r.mask))
      else $error("refused write changed mask");

endmodule

//--- sim/ivp_cpu_model.sv
// cpu core model on the far side of the interrupt map
// assumes pclk domain; level set by the bench, taken lines logged
`timescale 1ns/100ps
module ivp_cpu_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [1:0] set_level,
   input wire logic irq_req,
   input wire logic [4:0] irq_line,
   output logic [1:0] cpu_level,
   output logic [4:0] last_line
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_level <= 2'h3;
         last_line <= 5'h00;
      end else begin
         cpu_level <= set_level;
         if (irq_req) begin
            last_line <= irq_line;
         end
      end
   end
endmodule

//--- sim/tb.sv
// testbench for the interrupt vector and priority map
// assumes apb on pclk at 40 MHz and a cpu model on the far side
`timescale 1ns/100ps
module tb;
   import ivp_pkg::*;
   logic pclk = 0;
   logic presetn = 1;
   logic ce = 1;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] q;
   logic pready;
   logic pslverr;
   logic err;
   logic [7:0] ext_int = 8'h00;
   logic c0l = 0;
   logic c0h = 0;
   logic c1l = 0;
   logic c1h = 0;
   logic [23:0] oreq = 24'h0;
   logic [1:0] set_lvl = 2'h3;
   logic [1:0] cpu_level;
   logic [1:0] irq_lvl;
   logic irq;
   logic int_o;
   logic [4:0] irq_line;
   logic [4:0] last_line;
   logic [15:0] vu;
   logic [15:0] vl;
   int failures = 0;
   int num_checks = 0;
   int exp_line[11] = '{0, 1, 2, 2, 3, 3, 5, 6, 14, 22, 23};
   int ext_bit[6] = '{4, 5, 2, 6, 3, 7};

   ivp_map i_ivp_map (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_int(ext_int),
      .ct0_lo_req(c0l), .ct0_hi_req(c0h), .ct1_lo_req(c1l), .ct1_hi_req(c1h),
      .other_req(oreq), .cpu_level(cpu_level), .cpu_irq_req(irq),
      .cpu_irq_line(irq_line), .cpu_irq_level(irq_lvl), .cpu_vec_upper(vu),
      .cpu_vec_lower(vl), .int_o(int_o));
   ivp_cpu_model i_ivp_cpu_model (.pclk(pclk), .presetn(presetn), .set_level(set_lvl),
      .irq_req(irq), .irq_line(irq_line), .cpu_level(cpu_level), .last_line(last_line));

   initial begin
      forever #12.5 pclk = ~pclk;
   end

   task complete_run();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask

   // one apb transfer; waits for pready, takes data at that edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
      q = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask

   task src(input int i, input logic v);
      if (i < 6) ext_int[ext_bit[i]] <= v;
      else if (i == 6) c0l <= v;
      else if (i == 7) c0h <= v;
      else if (i == 8) c1h <= v;
      else if (i == 9) c1l <= v;
      else oreq[23] <= v;
   endtask

   task wait_irq(input logic v);
      int n;
      n = 0;
      while (irq !== v && n < 20) begin
         @(posedge pclk);
         n++;
      end
      chk("cpu_irq_req", {31'h0, v}, {31'h0, irq});
   endtask

   initial begin
      #500000;
      failures++;
      complete_run();
   end

   initial begin
      presetn <= 0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      for (int k = 0; k < 6; k++) begin
         apb(0, 12'h1e4 + 12'(4 * k), 32'h0);
         chk("level_reset", 32'hff, q);
         apb(1, 12'h1e4 + 12'(4 * k), 32'h0);
      end
      apb(0, 12'h1e8, 32'h0);
      chk("level_rw", 32'h0, q);
      apb(0, 12'h100, 32'h0);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1, 12'h204, 32'hffffff);
      for (int i = 0; i < 11; i++) begin
         src(i, 1);
         wait_irq(1);
         chk("line", exp_line[i], {27'h0, irq_line});
         chk("vec_upper", 16'hfffa - 16'(2 * exp_line[i]), {16'h0, vu});
         chk("vec_lower", 16'hfffb - 16'(2 * exp_line[i]), {16'h0, vl});
         chk("int_o", 32'h1, {31'h0, int_o});
         src(i, 0);
         apb(1, 12'h200, 32'hffffff);
         wait_irq(0);
      end
      apb(1, 12'h1e4, 32'h1);
      src(0, 1);
      src(10, 1);
      wait_irq(1);
      repeat (3) @(posedge pclk);
      chk("line_by_level", 32'd23, {27'h0, irq_line});
      src(6, 1);
      src(7, 1);
      repeat (4) @(posedge pclk);
      chk("line_tie", 32'd5, {27'h0, irq_line});
      chk("irq_level", 32'h0, {30'h0, irq_lvl});
      apb(0, 12'h208, 32'h0);
      chk("state", 32'h10005, q);
      set_lvl <= 0;
      repeat (4) @(posedge pclk);
      chk("irq_blocked", 32'h0, {31'h0, irq});
      set_lvl <= 1;
      wait_irq(1);
      chk("cpu_took", 32'd5, {27'h0, last_line});
      apb(1, 12'h204, 32'h0);
      repeat (3) @(posedge pclk);
      chk("masked_int_o", 32'h0, {31'h0, int_o});
      chk("masked_irq", 32'h0, {31'h0, irq});
      complete_run();
   end
endmodule
